//--- fault_flag_pkg.sv
// Constants and types for the fault flag register slice (bits 10..4).
// Assumes the register decode, enable register and detectors other than the frame length check live outside.
package fault_flag_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FAULT_FLAGS_OFFSET = 8'h06;
  localparam logic [7:0] FAULT_EN_OFFSET = 8'h07;
  localparam int REG_WIDTH = 16;
  localparam logic [15:0] FAULT_FLAGS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions, shared by the flag and enable registers
  // ----------------------------------------------------------------
  localparam int NEG_INPUT_RANGE_BIT = 10;
  localparam int REF_RANGE_BIT = 9;
  localparam int REF_DETECT_BIT = 8;
  localparam int CONV_FAULT_BIT = 7;
  localparam int IGNORED_ACCESS_BIT = 6;
  localparam int FRAME_LENGTH_BIT = 5;
  localparam int READ_ADDR_BIT = 4;
  localparam int LOW_BIT = 4;
  localparam int HIGH_BIT = 10;

  // ----------------------------------------------------------------
  // Serial frame checking
  // ----------------------------------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] BIT_CNT_ZERO = 3'h0;

  // Raw detector events, one-cycle pulses or levels
  typedef struct packed {
    logic neg_input_range;
    logic ref_range;
    logic ref_detect;
    logic clamp_pos;
    logic clamp_neg;
    logic cal_range;
    logic mod_sat;
    logic ignored_access;
    logic read_invalid_addr;
  } fault_events_t;

  // Register write port
  typedef struct packed {
    logic wr_en;
    logic [15:0] wr_data;
  } reg_write_t;

  typedef enum logic {FRAME_IDLE, FRAME_ACTIVE} frame_state_t;

endpackage : fault_flag_pkg

//--- frame_length_check.sv
// Serial frame length checker: counts clock pulses within a chip-select
// frame. Assumes cs_n and sclk_rise are already synchronous to ref_clk.
`timescale 1ns/10ps
module frame_length_check
  import fault_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial frame
  input wire logic cs_n,
  input wire logic sclk_rise,
  // Result
  output logic frame_err_r
);

  frame_state_t state_r, state_nxt;
  logic [BIT_CNT_W-1:0] cnt_r, cnt_nxt;
  logic frame_err_nxt;

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    frame_err_nxt = 1'b0;
    case (state_r)
      FRAME_IDLE:
      begin
        cnt_nxt = BIT_CNT_ZERO;
        if (!cs_n)
        begin
          state_nxt = FRAME_ACTIVE;
          cnt_nxt = sclk_rise ? 3'h1 : BIT_CNT_ZERO;
        end
      end
      FRAME_ACTIVE:
      begin
        if (cs_n)
        begin
          // Count wraps at eight, so any leftover means a partial byte
          frame_err_nxt = (cnt_r != BIT_CNT_ZERO); // [RQ6]
          state_nxt = FRAME_IDLE;
          cnt_nxt = BIT_CNT_ZERO;
        end
        else if (sclk_rise)
        begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      default:
      begin
        state_nxt = FRAME_IDLE;
        cnt_nxt = BIT_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= FRAME_IDLE;
      cnt_r <= BIT_CNT_ZERO;
      frame_err_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      frame_err_r <= frame_err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_frame_err_cause;
    @(posedge ref_clk) disable iff (!rst_n)
    frame_err_r |-> $past(cs_n) && $past(state_r == FRAME_ACTIVE)
      && $past(cnt_r != BIT_CNT_ZERO);
  endproperty
  a_frame_err_cause: assert property (p_frame_err_cause) // [RQ6]
    else $error("frame error without a partial byte");

  property p_full_byte_no_err;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_r == FRAME_ACTIVE && cs_n && cnt_r == BIT_CNT_ZERO)
      |=> !frame_err_r;
  endproperty
  a_full_byte_no_err: assert property (p_full_byte_no_err) // [RQ6]
    else $error("frame error on whole bytes");

  c_frame_err: cover property (@(posedge ref_clk) disable iff (!rst_n)
    frame_err_r);

endmodule : frame_length_check

//--- fault_flag_register.sv
// Fault flag register slice: sticky write-one-to-clear flags 10..4.
// Assumes register decode, enable register and detectors other than the frame length check are outside;
// all inputs are synchronous to ref_clk.
//
// Contract
// [RQ1] Bit 10 sets on negative input range fault
// [RQ2] Bit 9 sets on reference range fault
// [RQ3] Bit 8 sets on missing external reference
// [RQ4] Bit 7 sets on clamp, calibration, saturation
// [RQ5] Bit 6 sets on access while ignored
// [RQ6] Bit 5 sets on non-byte frame length
// [RQ7] Bit 4 sets on invalid address read
// [RQ8] Flags act only when enabled
// [RQ9] Writing one clears, zero leaves unchanged
// [RQ10] Flags stay set until cleared or reset
`timescale 1ns/10ps
module fault_flag_register
  import fault_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register access
  input wire reg_write_t reg_wr,
  input wire logic [REG_WIDTH-1:0] fault_en,
  output logic [REG_WIDTH-1:0] fault_flags_r,
  // Detector events
  input wire fault_events_t events,
  // Serial frame
  input wire logic cs_n,
  input wire logic sclk_rise
);

  logic [REG_WIDTH-1:0] fault_flags_nxt;
  logic [REG_WIDTH-1:0] cause;
  logic [REG_WIDTH-1:0] set_vec;
  logic [REG_WIDTH-1:0] clr_vec;
  logic frame_err_r;

  // ----------------------------------------------------------------
  // Frame length checking
  // ----------------------------------------------------------------
  frame_length_check u_frame_check (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk_rise(sclk_rise),
    .frame_err_r(frame_err_r)
  );

  // ----------------------------------------------------------------
  // Causes
  // ----------------------------------------------------------------
  always_comb
  begin
    cause = '0;
    cause[NEG_INPUT_RANGE_BIT] = events.neg_input_range; // [RQ1]
    cause[REF_RANGE_BIT] = events.ref_range; // [RQ2]
    cause[REF_DETECT_BIT] = events.ref_detect; // [RQ3]
    cause[CONV_FAULT_BIT] = events.clamp_pos | events.clamp_neg
      | events.cal_range | events.mod_sat; // [RQ4]
    cause[IGNORED_ACCESS_BIT] = events.ignored_access; // [RQ5]
    cause[FRAME_LENGTH_BIT] = frame_err_r; // [RQ6]
    cause[READ_ADDR_BIT] = events.read_invalid_addr; // [RQ7]
  end

  // ----------------------------------------------------------------
  // Flag bits
  // ----------------------------------------------------------------
  // Bits outside 10..4 belong to other slices and read as zero here
  genvar gi;
  generate
    for (gi = 0; gi < REG_WIDTH; gi++)
    begin : g_flag
      if (gi >= LOW_BIT && gi <= HIGH_BIT)
      begin : g_live
        assign set_vec[gi] = cause[gi] & fault_en[gi]; // [RQ8]
        assign clr_vec[gi] = reg_wr.wr_en & reg_wr.wr_data[gi]; // [RQ9]
        // Set beats clear so a fault in the clearing cycle is kept
        assign fault_flags_nxt[gi] = set_vec[gi]
          | (fault_flags_r[gi] & ~clr_vec[gi]); // [RQ10]
      end
      else
      begin : g_none
        assign set_vec[gi] = 1'b0;
        assign clr_vec[gi] = 1'b0;
        assign fault_flags_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_flags_r <= FAULT_FLAGS_RESET;
    end
    else
    begin
      fault_flags_r <= fault_flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_neg_input_set;
    @(posedge ref_clk) disable iff (!rst_n)
    events.neg_input_range && fault_en[NEG_INPUT_RANGE_BIT]
      |=> fault_flags_r[NEG_INPUT_RANGE_BIT];
  endproperty
  a_neg_input_set: assert property (p_neg_input_set) // [RQ1]
    else $error("bit 10 not set on input range fault");

  property p_ref_range_set;
    @(posedge ref_clk) disable iff (!rst_n)
    events.ref_range && fault_en[REF_RANGE_BIT]
      |=> fault_flags_r[REF_RANGE_BIT];
  endproperty
  a_ref_range_set: assert property (p_ref_range_set) // [RQ2]
    else $error("bit 9 not set on reference range fault");

  property p_ref_detect_set;
    @(posedge ref_clk) disable iff (!rst_n)
    events.ref_detect && fault_en[REF_DETECT_BIT]
      |=> fault_flags_r[REF_DETECT_BIT];
  endproperty
  a_ref_detect_set: assert property (p_ref_detect_set) // [RQ3]
    else $error("bit 8 not set on missing reference");

  property p_conv_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (events.clamp_pos || events.clamp_neg || events.cal_range
      || events.mod_sat) && fault_en[CONV_FAULT_BIT]
      |=> fault_flags_r[CONV_FAULT_BIT];
  endproperty
  a_conv_set: assert property (p_conv_set) // [RQ4]
    else $error("bit 7 not set on conversion fault");

  property p_ignored_set;
    @(posedge ref_clk) disable iff (!rst_n)
    events.ignored_access && fault_en[IGNORED_ACCESS_BIT]
      |=> fault_flags_r[IGNORED_ACCESS_BIT];
  endproperty
  a_ignored_set: assert property (p_ignored_set) // [RQ5]
    else $error("bit 6 not set on ignored access");

  property p_frame_set;
    @(posedge ref_clk) disable iff (!rst_n)
    frame_err_r && fault_en[FRAME_LENGTH_BIT]
      |=> fault_flags_r[FRAME_LENGTH_BIT];
  endproperty
  a_frame_set: assert property (p_frame_set) // [RQ6]
    else $error("bit 5 not set on frame length fault");

  // Bit 5 may only rise after the checker has flagged a partial byte
  property p_frame_no_spurious;
    @(posedge ref_clk) disable iff (!rst_n)
    !fault_flags_r[FRAME_LENGTH_BIT] && !frame_err_r
      |=> !fault_flags_r[FRAME_LENGTH_BIT];
  endproperty
  a_frame_no_spurious: assert property (p_frame_no_spurious) // [RQ6]
    else $error("bit 5 set without a frame fault");

  property p_read_addr_set;
    @(posedge ref_clk) disable iff (!rst_n)
    events.read_invalid_addr && fault_en[READ_ADDR_BIT]
      |=> fault_flags_r[READ_ADDR_BIT];
  endproperty
  a_read_addr_set: assert property (p_read_addr_set) // [RQ7]
    else $error("bit 4 not set on invalid read");

  property p_disabled_no_rise;
    @(posedge ref_clk) disable iff (!rst_n)
    (fault_en[HIGH_BIT:LOW_BIT] == '0) |=>
      (fault_flags_r[HIGH_BIT:LOW_BIT]
        & ~$past(fault_flags_r[HIGH_BIT:LOW_BIT])) == '0;
  endproperty
  a_disabled_no_rise: assert property (p_disabled_no_rise) // [RQ8]
    else $error("flag rose while disabled");

  property p_w1c;
    @(posedge ref_clk) disable iff (!rst_n)
    reg_wr.wr_en && reg_wr.wr_data[REF_RANGE_BIT]
      && !(events.ref_range && fault_en[REF_RANGE_BIT])
      |=> !fault_flags_r[REF_RANGE_BIT];
  endproperty
  a_w1c: assert property (p_w1c) // [RQ9]
    else $error("write of one did not clear bit 9");

  property p_neg_input_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    reg_wr.wr_en && reg_wr.wr_data[NEG_INPUT_RANGE_BIT]
      && !events.neg_input_range |=> !fault_flags_r[NEG_INPUT_RANGE_BIT];
  endproperty
  a_neg_input_clear: assert property (p_neg_input_clear) // [RQ9]
    else $error("write of one did not clear bit 10");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
    fault_flags_r[CONV_FAULT_BIT]
      && !(reg_wr.wr_en && reg_wr.wr_data[CONV_FAULT_BIT])
      |=> fault_flags_r[CONV_FAULT_BIT] [*1];
  endproperty
  a_sticky: assert property (p_sticky) // [RQ10]
    else $error("bit 7 dropped without a clear");

  property p_outside_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    1'b1 |-> fault_flags_r[REG_WIDTH-1:HIGH_BIT+1] == '0
      && fault_flags_r[LOW_BIT-1:0] == '0;
  endproperty
  a_outside_zero: assert property (p_outside_zero)
    else $error("bit outside slice set");

  c_conv_flag: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(fault_flags_r[CONV_FAULT_BIT]));
  c_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(fault_flags_r[NEG_INPUT_RANGE_BIT]));
  c_set_on_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr.wr_en && reg_wr.wr_data[READ_ADDR_BIT]
      && events.read_invalid_addr && fault_en[READ_ADDR_BIT]);

endmodule : fault_flag_register

//--- spi_host_model.sv
// Host model: enables flags, clears them and frames serial transfers.
// Assumes its tasks are called 1 ns after a rising edge, after reset.
`timescale 1ns/10ps
module spi_host_model
  import fault_flag_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Device side
  output reg_write_t reg_wr,
  output logic [15:0] fault_en,
  output logic cs_n,
  output logic sclk_rise
);
  initial
  begin
    reg_wr = '0;
    fault_en = 16'h0000;
    cs_n = 1'b1;
    sclk_rise = 1'b0;
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  task automatic set_en(input logic [15:0] d);
    fault_en = d;
  endtask : set_en

  // One-cycle write; returns when the clear is visible
  task automatic wr_clear(input logic [15:0] d);
    reg_wr.wr_data = d;
    reg_wr.wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr.wr_en = 1'b0;
  endtask : wr_clear

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  // An empty frame still holds select low for one cycle
  task automatic frame(input int n);
    cs_n = 1'b0;
    for (int k = 0; k < n || k == 0; k++)
    begin
      sclk_rise = (n > 0);
      @(posedge ref_clk);
      #1;
    end
    // Serial clock stands still outside frames
    sclk_rise = 1'b0;
    cs_n = 1'b1;
  endtask : frame
endmodule : spi_host_model

//--- fault_flag_register_tb_top.sv
// Bench for the fault flag slice: event table, then hand tests.
// Assumes the host model drives register and serial inputs.
`timescale 1ns/10ps
module fault_flag_register_tb_top
  import fault_flag_pkg::*;
;
  typedef struct packed {
    logic [8:0] ev;
    logic [15:0] en;
    logic [15:0] exp;
  } row_t;

  logic ref_clk;
  logic rst_n;
  fault_events_t events;
  reg_write_t reg_wr;
  logic [15:0] fault_en;
  logic [15:0] fault_flags_r;
  logic cs_n;
  logic sclk_rise;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lens[6] = '{8, 16, 3, 9, 7, 0};
  row_t rows[11] = '{
    '{9'h100, 16'h0400, 16'h0400},
    '{9'h080, 16'h0200, 16'h0200},
    '{9'h040, 16'h0100, 16'h0100},
    '{9'h020, 16'h0080, 16'h0080},
    '{9'h010, 16'h0080, 16'h0080},
    '{9'h008, 16'h0080, 16'h0080},
    '{9'h004, 16'h0080, 16'h0080},
    '{9'h002, 16'h0040, 16'h0040},
    '{9'h001, 16'h0010, 16'h0010},
    '{9'h1ff, 16'h0000, 16'h0000},
    '{9'h1ff, 16'hffff, 16'h07d0}
  };

  fault_flag_register fault_flag_register_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .fault_en(fault_en),
    .fault_flags_r(fault_flags_r),
    .events(events),
    .cs_n(cs_n),
    .sclk_rise(sclk_rise)
  );

  spi_host_model spi_host_model_inst (
    .ref_clk(ref_clk),
    .reg_wr(reg_wr),
    .fault_en(fault_en),
    .cs_n(cs_n),
    .sclk_rise(sclk_rise)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] exp);
    cmp_count++;
    if (fault_flags_r !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t flags %h expected %h", $time, fault_flags_r, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // Whole run needs about 124 cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    events = '0;
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk(16'h0000);
    $display("test reset done");
    for (int i = 0; i < 11; i++)
    begin
      spi_host_model_inst.set_en(rows[i].en);
      events = rows[i].ev;
      @(posedge ref_clk);
      #1 events = '0;
      chk(rows[i].exp);
      @(posedge ref_clk);
      #1 chk(rows[i].exp);
      spi_host_model_inst.wr_clear(16'hffff);
      chk(16'h0000);
    end
    $display("test event table done");
    spi_host_model_inst.set_en(16'hffff);
    events = 9'h1ff;
    @(posedge ref_clk);
    #1 events = '0;
    spi_host_model_inst.wr_clear(16'h0050);
    chk(16'h0780);
    // Dropping the enable must not wipe a set flag
    spi_host_model_inst.set_en(16'h0000);
    @(posedge ref_clk);
    #1 chk(16'h0780);
    spi_host_model_inst.wr_clear(16'h0000);
    chk(16'h0780);
    // Fault and clear in one cycle: the fault is kept
    spi_host_model_inst.set_en(16'hffff);
    @(posedge ref_clk);
    #1 events = 9'h005;
    spi_host_model_inst.wr_clear(16'h0090);
    events = '0;
    chk(16'h0790);
    @(posedge ref_clk);
    #1 spi_host_model_inst.wr_clear(16'hffff);
    chk(16'h0000);
    $display("test clear done");
    foreach (lens[j])
    begin
      spi_host_model_inst.frame(lens[j]);
      repeat (3) @(posedge ref_clk);
      #1 chk((lens[j] % BITS_PER_BYTE != 0) ? 16'h0020 : 16'h0000);
      spi_host_model_inst.wr_clear(16'hffff);
    end
    spi_host_model_inst.set_en(16'hffdf);
    spi_host_model_inst.frame(5);
    repeat (3) @(posedge ref_clk);
    #1 chk(16'h0000);
    $display("test frame done");
    // Reset in mid-run wipes every set flag at once
    events = 9'h1ff;
    @(posedge ref_clk);
    #1 events = '0;
    chk(16'h07d0);
    rst_n = 1'b0;
    #1 chk(16'h0000);
    @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk(16'h0000);
    @(posedge ref_clk);
    #1 chk(16'h0000);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : fault_flag_register_tb_top
